/* File: fwss_defs.svh */
`ifndef FWSS_DEFS_SVH
`define FWSS_DEFS_SVH

// ----------------------------------------------------------------------
// Default geometry
// ----------------------------------------------------------------------
`define FWSS_DEPTH 512
`define FWSS_DATA_W 16
`define FWSS_COUNT_W 10

// ----------------------------------------------------------------------
// Reset timing
// ----------------------------------------------------------------------
// The busy flag stays high for this many cycles plus one after reset release.
`define FWSS_RST_BUSY_CYC 4
`define FWSS_RST_BUSY_CNT_W 3

// ----------------------------------------------------------------------
// Error injection bit positions within the stored codeword
// ----------------------------------------------------------------------
`define FWSS_INJ_BIT_A 0
`define FWSS_INJ_BIT_B 1

`endif

/* File: fwss_pkg.sv */
package fwss_pkg;

  // Threshold arrangement for the programmable-full flag.
  typedef enum logic {
    FWSS_THR_SINGLE,
    FWSS_THR_DUAL
  } fwss_thr_mode_e;

  // Reset sequencing of the write domain.
  typedef enum logic [1:0] {
    FWSS_ST_RESET,
    FWSS_ST_BUSY,
    FWSS_ST_RUN
  } fwss_state_e;

endpackage : fwss_pkg

/* File: fwss_pfull.sv */
`timescale 1ns/100ps

// Hysteresis flag: sets at or above the assert level, clears below the negate level.
module fwss_pfull
  import fwss_pkg::*;
#(
  parameter int CNTW = 10
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic hold,
  input wire logic [CNTW-1:0] occupancy,
  input wire logic [CNTW-1:0] thr_assert,
  input wire logic [CNTW-1:0] thr_negate,
  output logic flag_ff
);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flag_ff <= 1'b0;
    end else if (hold) begin
      flag_ff <= 1'b0;
    end else if (occupancy >= thr_assert) begin
      flag_ff <= 1'b1;
    end else if (occupancy < thr_negate) begin
      flag_ff <= 1'b0;
    end
  end

endmodule // fwss_pfull

/* File: fwss_top.sv */
`timescale 1ns/100ps
`include "fwss_defs.svh"

module fwss_top
  import fwss_pkg::*;
#(
  parameter int DEPTH = `FWSS_DEPTH,
  parameter int DATA_W = `FWSS_DATA_W,
  parameter int COUNT_W = `FWSS_COUNT_W,
  parameter bit ECC_EN = 1'b1,
  parameter fwss_thr_mode_e THR_MODE = FWSS_THR_SINGLE
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [DATA_W-1:0] din,
  input wire logic inject_single,
  input wire logic inject_double,
  input wire logic word_retire,
  input wire logic [$clog2(DEPTH):0] thr_single,
  input wire logic [$clog2(DEPTH):0] thr_assert,
  input wire logic [$clog2(DEPTH):0] thr_negate,
  output logic mem_we_ff,
  output logic [$clog2(DEPTH)-1:0] mem_addr_ff,
  output logic [DATA_W-1:0] mem_din_ff,
  output logic full_ff,
  output logic wr_ack_ff,
  output logic overflow_ff,
  output logic [COUNT_W-1:0] wr_count_ff,
  output logic prog_full_ff,
  output logic wr_rst_busy_ff
);

  localparam int AW = $clog2(DEPTH);
  localparam int CNTW = AW + 1;
  localparam logic [CNTW-1:0] DEPTH_C = CNTW'(DEPTH);

  fwss_state_e state_ff;
  logic [`FWSS_RST_BUSY_CNT_W-1:0] busy_cnt_ff;
  logic [CNTW-1:0] occ_ff;
  logic [CNTW-1:0] nxt_occ;
  logic [CNTW-1:0] thr_asrt_ff;
  logic [CNTW-1:0] thr_neg_ff;
  logic [DATA_W-1:0] nxt_flip;
  logic accept;
  logic refuse;
  logic retire;
  logic running;

  // ----------------------------------------------------------------------
  // Reset sequencing
  // ----------------------------------------------------------------------
  // Busy stays up a few cycles after release so thresholds settle before use.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= FWSS_ST_RESET;
      busy_cnt_ff <= '0;
      wr_rst_busy_ff <= 1'b1;
    end else begin
      case (state_ff)
        FWSS_ST_RESET: begin
          state_ff <= FWSS_ST_BUSY;
          busy_cnt_ff <= '0;
        end
        FWSS_ST_BUSY: begin
          if (busy_cnt_ff == `FWSS_RST_BUSY_CNT_W'(`FWSS_RST_BUSY_CYC - 1)) begin
            state_ff <= FWSS_ST_RUN;
            wr_rst_busy_ff <= 1'b0;
          end else begin
            busy_cnt_ff <= busy_cnt_ff + 1'b1;
          end
        end
        default: begin
          state_ff <= FWSS_ST_RUN;
        end
      endcase
    end
  end

  assign running = (state_ff == FWSS_ST_RUN);

  // ----------------------------------------------------------------------
  // Threshold capture
  // ----------------------------------------------------------------------
  // Thresholds are sampled only while busy; a run-time change needs a reset.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      thr_asrt_ff <= '1;
      thr_neg_ff <= '1;
    end else if (!running) begin
      if (THR_MODE == FWSS_THR_SINGLE) begin
        thr_asrt_ff <= thr_single;
        thr_neg_ff <= thr_single;
      end else begin
        thr_asrt_ff <= thr_assert;
        thr_neg_ff <= thr_negate;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Write acceptance and occupancy
  // ----------------------------------------------------------------------
  assign accept = running && wr_en && !full_ff;
  assign refuse = running && wr_en && full_ff;
  assign retire = running && word_retire && (occ_ff != '0);

  // A late retire only leaves the count high, which is the safe direction.
  always_comb begin
    nxt_occ = occ_ff;
    if (accept && !retire) begin
      nxt_occ = occ_ff + 1'b1;
    end else if (retire && !accept) begin
      nxt_occ = occ_ff - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      occ_ff <= '0;
      full_ff <= 1'b0;
      wr_count_ff <= '0;
    end else begin
      occ_ff <= nxt_occ;
      full_ff <= (nxt_occ == DEPTH_C);
      wr_count_ff <= nxt_occ[CNTW-1 -: COUNT_W];
    end
  end

  // ----------------------------------------------------------------------
  // Status pulses
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ack_ff <= 1'b0;
      overflow_ff <= 1'b0;
    end else begin
      wr_ack_ff <= accept;
      overflow_ff <= refuse;
    end
  end

  // ----------------------------------------------------------------------
  // Storage write port with error injection
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_flip = '0;
    if (ECC_EN && inject_double) begin
      nxt_flip[`FWSS_INJ_BIT_A] = 1'b1;
      nxt_flip[`FWSS_INJ_BIT_B] = 1'b1;
    end else if (ECC_EN && inject_single) begin
      nxt_flip[`FWSS_INJ_BIT_A] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mem_we_ff <= 1'b0;
      mem_addr_ff <= '0;
      mem_din_ff <= '0;
    end else begin
      mem_we_ff <= accept;
      if (accept) begin
        mem_din_ff <= din ^ nxt_flip;
      end
      if (mem_we_ff) begin
        mem_addr_ff <= mem_addr_ff + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Programmable full
  // ----------------------------------------------------------------------
  fwss_pfull #(
    .CNTW(CNTW)
  ) u_pfull (
    .mclk(mclk),
    .arst_n(arst_n),
    .hold(!running),
    .occupancy(nxt_occ),
    .thr_assert(thr_asrt_ff),
    .thr_negate(thr_neg_ff),
    .flag_ff(prog_full_ff)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_ack_after_write: assert property (accept |=> wr_ack_ff && !overflow_ff)
    else $error("Acknowledge missing after accepted write.");
  a_ovf_after_full: assert property (refuse |=> overflow_ff && !wr_ack_ff)
    else $error("Overflow missing after refused write.");
  a_refuse_keeps_state: assert property (refuse && !retire |=> $stable(occ_ff))
    else $error("Refused write changed occupancy.");
  a_count_next_edge: assert property (accept && !retire |=> occ_ff == $past(occ_ff) + 1'b1)
    else $error("Accepted write not counted at next edge.");
  a_count_msbs: assert property (wr_count_ff == occ_ff[CNTW-1 -: COUNT_W])
    else $error("Count bus does not show occupancy msbs.");
  a_pfull_sets: assert property (running && nxt_occ >= thr_asrt_ff |=> prog_full_ff)
    else $error("Programmable full did not assert.");
  a_pfull_holds: assert property (running && prog_full_ff && nxt_occ >= thr_neg_ff
    |=> prog_full_ff)
    else $error("Programmable full dropped above negate level.");
  a_thr_frozen: assert property (running |=> $stable(thr_asrt_ff) && $stable(thr_neg_ff))
    else $error("Threshold changed outside reset.");
  a_busy_no_store: assert property (wr_rst_busy_ff |=> !mem_we_ff)
    else $error("Write stored while reset busy.");
  a_inject_double: assert property (accept && ECC_EN && inject_double
    |=> mem_din_ff == ($past(din) ^ DATA_W'(3)))
    else $error("Double injection did not flip two bits.");
  a_inject_single: assert property (accept && ECC_EN && inject_single && !inject_double
    |=> mem_din_ff == ($past(din) ^ DATA_W'(1)))
    else $error("Single injection did not flip one bit.");

  c_fill_to_full: cover property (accept ##1 full_ff);
  c_overflow: cover property (refuse ##1 overflow_ff);
  c_pfull_cycle: cover property (prog_full_ff ##[1:1000] !prog_full_ff);

endmodule // fwss_top

/* File: fwss_writer.sv */
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// User write-side logic
// ----------------------------------------------------------------------
// Requests stop while the write domain is busy in reset, and the data
// bus toggles between requests so that a stale word never looks valid.
module fwss_writer #(
  parameter int DATA_W = 16
) (
  input wire logic mclk,
  input wire logic busy,
  input wire logic [3:0] rate,
  output logic wr_en,
  output logic [DATA_W-1:0] din,
  output logic inject_single,
  output logic inject_double
);
  initial begin
    wr_en = 1'b0;
    din = '0;
    inject_single = 1'b0;
    inject_double = 1'b0;
  end

  always @(posedge mclk) begin : drive
    logic go;
    go = !busy && (($urandom % 16) < rate);
    wr_en <= go;
    din <= go ? DATA_W'($urandom) : ~din;
    // Injection also pulses on idle and refused cycles, where it must leave no trace.
    inject_single <= ($urandom % 4 == 0);
    inject_double <= ($urandom % 8 == 0);
  end
endmodule // fwss_writer

/* File: fwss_tb_top.sv */
`timescale 1ns/100ps
`include "fwss_defs.svh"

module fwss_tb_top
  import fwss_pkg::*;
;
  // ----------------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------------
  // A shallow store and a narrow count keep fills short and drop one bit.
  localparam int DEPTH = 16;
  localparam int CW = 4;
  logic mclk, arst_n, wr_en, inj_s, inj_d, retire, ack, ovf, we, full, pf, busy;
  // The model keeps its own count of the busy window after release.
  localparam int RUN_AT = `FWSS_RST_BUSY_CYC + 1;
  logic e_ack, e_ovf, e_we, e_pf, pf1, e_pf1;
  logic [15:0] din, mdin, e_din, mdin1, e_raw;
  logic [3:0] addr, e_addr, rate;
  logic [4:0] ta, tn;
  logic [CW-1:0] cnt;
  int errors, tests_run, occ, wptr, ret_rate, rcnt;

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  fwss_writer #(.DATA_W(16)) i_fwss_writer (.mclk(mclk), .busy(busy), .rate(rate),
    .wr_en(wr_en), .din(din), .inject_single(inj_s), .inject_double(inj_d));

  fwss_top #(.DEPTH(DEPTH), .DATA_W(16), .COUNT_W(CW), .ECC_EN(1'b1),
    .THR_MODE(FWSS_THR_DUAL)) i_fwss_top (.mclk(mclk), .arst_n(arst_n), .wr_en(wr_en),
    .din(din), .inject_single(inj_s), .inject_double(inj_d), .word_retire(retire),
    .thr_single(ta), .thr_assert(ta), .thr_negate(tn), .mem_we_ff(we), .mem_addr_ff(addr),
    .mem_din_ff(mdin), .full_ff(full), .wr_ack_ff(ack), .overflow_ff(ovf),
    .wr_count_ff(cnt), .prog_full_ff(pf), .wr_rst_busy_ff(busy));

  // Single-threshold copy without ECC; its assert and negate pins carry the other level,
  // so picking the wrong threshold input shows on its flag.
  fwss_top #(.DEPTH(DEPTH), .DATA_W(16), .COUNT_W(CW), .ECC_EN(1'b0),
    .THR_MODE(FWSS_THR_SINGLE)) i_fwss_top_single (.mclk(mclk), .arst_n(arst_n),
    .wr_en(wr_en), .din(din), .inject_single(inj_s), .inject_double(inj_d),
    .word_retire(retire), .thr_single(ta), .thr_assert(tn), .thr_negate(tn), .mem_we_ff(),
    .mem_addr_ff(), .mem_din_ff(mdin1), .full_ff(), .wr_ack_ff(), .overflow_ff(),
    .wr_count_ff(), .prog_full_ff(pf1), .wr_rst_busy_ff());

  // ----------------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------------
  always @(posedge mclk or negedge arst_n) begin : model
    logic acc;
    logic rt;
    if (!arst_n) begin
      occ = 0; wptr = 0; e_ack = 0; e_ovf = 0; e_we = 0; e_pf = 0;
      e_pf1 = 0;
      rcnt = 0;
    end else if (rcnt < RUN_AT) begin
      rcnt++;
    end else begin
      acc = wr_en && (occ != DEPTH);
      rt = retire && (occ != 0);
      e_ack = acc;
      e_ovf = wr_en && !acc;
      e_we = acc;
      e_din = din ^ (inj_d ? 16'h0003 : {15'h0000, inj_s});
      e_raw = din;
      e_addr = 4'(wptr);
      if (acc) wptr = (wptr + 1) % DEPTH;
      occ = occ + int'(acc) - int'(rt);
      if (occ >= ta) e_pf = 1'b1;
      else if (occ < tn) e_pf = 1'b0;
      e_pf1 = (occ >= ta);
    end
  end

  always @(posedge mclk) retire <= ($urandom % 16) < ret_rate;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  always @(negedge mclk) if (arst_n) begin
    chk(busy, rcnt < RUN_AT);
    if (rcnt >= RUN_AT) begin
      chk(ack, e_ack);
      chk(ovf, e_ovf);
      chk(cnt, 16'(occ >> 1));
      chk(full, occ == DEPTH);
      chk(pf, e_pf);
      chk(pf1, e_pf1);
      chk(we, e_we);
      if (e_we) begin
        chk(mdin, e_din);
        chk(mdin1, e_raw);
        chk(addr, e_addr);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  task automatic do_reset(input logic [4:0] a, input logic [4:0] n);
    arst_n <= 1'b0;
    ta <= a;
    tn <= n;
    repeat (12) @(posedge mclk);
    chk(busy, 1'b1);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    #1 chk(busy, 1'b1);
    @(posedge mclk);
    #1 chk(busy, 1'b0);
    $display("reset test done");
  endtask

  task automatic run(input string name, input logic [3:0] w, input int r, input int n);
    @(posedge mclk);
    rate <= w;
    ret_rate <= r;
    repeat (n) @(posedge mclk);
    $display("%s test done", name);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    arst_n = 1'b0; rate = 4'h0; ret_rate = 0; retire = 1'b0; ta = 5'h0c; tn = 5'h08;
    void'($urandom(32'h82d6d1a0));
    @(posedge mclk);
    do_reset(5'h0c, 5'h08);
    run("fill", 4'hf, 0, 60);
    run("drain", 4'h0, 15, 40);
    run("mixed", 4'h8, 8, 400);
    do_reset(5'h05, 5'h03);
    run("rethreshold", 4'ha, 6, 300);
    run("edge", 4'hf, 14, 200);
    do_reset(5'h10, 5'h10);
    run("full threshold", 4'hc, 4, 150);
    do_reset(5'(1 + $urandom % 16), 5'($urandom % 16));
    run("random", 4'(8 + $urandom % 8), 8, 200);
    end_of_test();
  end

  initial begin
    #(3000 * 40);
    errors++;
    end_of_test();
  end
endmodule // fwss_tb_top
